// [common/sfp_pkg.sv]
package sfp_pkg;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_SET_LATCH = 8'h06;
	localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
	localparam logic [7:0] OPC_STATUS_RD = 8'h05;
	localparam logic [7:0] OPC_STATUS_WR = 8'h01;
	localparam logic [7:0] OPC_MEM_READ  = 8'h03;
	localparam logic [7:0] OPC_FAST_READ = 8'h0B;
	localparam logic [7:0] OPC_MEM_WRITE = 8'h02;
	localparam logic [7:0] OPC_SLEEP     = 8'hB9;
	localparam logic [7:0] OPC_IDENT     = 8'h9F;

	// ----------------------------------------------------------------
	// Framing and address
	// ----------------------------------------------------------------
	localparam int          ADDR_W    = 18;
	localparam logic [2:0]  BIT_LAST  = 3'h7;
	localparam logic [1:0]  ADDR_LAST = 2'h2;
	localparam logic [17:0] GUARD_QTR_BASE  = 18'h30000;
	localparam logic [17:0] GUARD_HALF_BASE = 18'h20000;

	// ----------------------------------------------------------------
	// Status register layout and reset values
	// ----------------------------------------------------------------
	localparam int         SR_PIN_EN   = 7;
	localparam int         SR_GUARD_HI = 3;
	localparam int         SR_GUARD_LO = 2;
	localparam int         SR_LATCH    = 1;
	localparam logic [7:0] SR_FIXED    = 8'h40;
	localparam int         NV_HI       = 1;
	localparam int         NV_LO       = 0;
	localparam logic       LATCH_RST   = 1'b0;
	localparam logic       PIN_EN_RST  = 1'b0;
	localparam logic [1:0] GUARD_RST   = 2'h0;
	localparam logic [1:0] GUARD_NONE  = 2'h0;
	localparam logic [1:0] GUARD_QTR   = 2'h1;
	localparam logic [1:0] GUARD_HALF  = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE       = 3'h0,
		ST_OPCODE     = 3'h1,
		ST_ADDR       = 3'h2,
		ST_DATA       = 3'h3,
		ST_STATUS_OUT = 3'h4,
		ST_STATUS_IN  = 3'h5,
		ST_DONE       = 3'h6,
		ST_IGNORE     = 3'h7
	} sfp_state_e;

	// Address falls in a guarded block
	function automatic logic sfp_guarded(input logic [17:0] a, input logic [1:0] g);
		case (g)
			GUARD_NONE: sfp_guarded = 1'b0;
			GUARD_QTR:  sfp_guarded = (a >= GUARD_QTR_BASE);
			GUARD_HALF: sfp_guarded = (a >= GUARD_HALF_BASE);
			default:    sfp_guarded = 1'b1;
		endcase
	endfunction

endpackage

// [common/sfp_nv_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface sfp_nv_if;
	logic       wr_en;
	logic [1:0] wr_data;
	logic [1:0] bits;

	modport ctrl  (output wr_en, output wr_data, input bits);
	modport store (input wr_en, input wr_data, output bits);
endinterface
`default_nettype wire

// [design/sfp_guard_store.sv]
`timescale 1ns/10ps
`default_nettype none
module sfp_guard_store
	import sfp_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_nv_rst_n,
	sfp_nv_if.store   nv
);

	logic [1:0] bits_reg;
	logic [1:0] bits_next;

	// Power reset never reaches here; only the factory init clears it
	always_comb begin
		bits_next = nv.wr_en ? nv.wr_data : bits_reg;
	end

	always_ff @(posedge i_clk or negedge i_nv_rst_n) begin
		if (!i_nv_rst_n) begin
			bits_reg <= GUARD_RST;
		end else begin
			bits_reg <= bits_next;
		end
	end

	assign nv.bits = bits_reg;

endmodule
`default_nettype wire

// [design/sfp_cmd_protect.sv]
`timescale 1ns/10ps
`default_nettype none
// Function
// - Inputs sampled on SCK rise, output changed on SCK fall.
// - SCK level at select picks mode 0 or mode 3.
// - All bytes move most significant bit first.
// - Three address bytes taken; only the low 18 bits kept.
// - First byte after select is the opcode.
// - Unknown opcode ignored with rest of frame; output stays off.
// - Decode set-latch 06, clear-latch 04, status-write 01, write 02.
// - Decode status-read 05, read 03, fast read 0B, sleep B9, ident 9F.
// - Latch clear after power-up; writes refused until set.
// - Only the set-latch command sets the latch flag.
// - Latch cleared at deselect after clear-latch, status-write or write.
// - Status write data cannot set the latch flag; deselect clears it.
// - Status: bit7 pin enable, bits3/2 guards, bit1 latch flag.
// - Bits 0, 4, 5 read zero, bit 6 reads one; unwritable.
// - Guard bits survive power cycles.
// - Guard code selects protected range for memory writes.
// - Status write refused when latch clear, or when pin enable set and pin low.
// - Guarded blocks never writable; latch clear protects everything.
// - Clear-latch disables writes; status then reads flag zero.
// - One opcode per selection, each starting at select.
// - Deselected: input ignored, output high impedance.
// - Status-read returns the current status byte.
module sfp_cmd_protect
	import sfp_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_nv_rst_n,
	input  wire logic              i_cs_n,
	input  wire logic              i_sck,
	input  wire logic              i_si,
	input  wire logic              i_wp_n,
	output logic                   o_so,
	output logic                   o_so_oe_n,
	output logic [7:0]             o_opcode,
	output logic                   o_opcode_valid,
	output logic [ADDR_W-1:0]      o_addr,
	output logic                   o_addr_valid,
	output logic [7:0]             o_data_byte,
	output logic                   o_data_valid,
	output logic                   o_write_permit,
	output logic [7:0]             o_status,
	output logic                   o_mode3,
	output logic                   o_selected,
	output logic                   o_frame_end
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic cs_s1, cs_s2, cs_d;
	logic sck_s1, sck_s2, sck_d;
	logic si_s1, si_s2;
	logic wp_s1, wp_s2;

	// Two stages per pin, plus one delay on CS and SCK for edge finding
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cs_s1  <= 1'b1;
			cs_s2  <= 1'b1;
			cs_d   <= 1'b1;
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_d  <= 1'b0;
			si_s1  <= 1'b0;
			si_s2  <= 1'b0;
			wp_s1  <= 1'b1;
			wp_s2  <= 1'b1;
		end else begin
			cs_s1  <= i_cs_n;
			cs_s2  <= cs_s1;
			cs_d   <= cs_s2;
			sck_s1 <= i_sck;
			sck_s2 <= sck_s1;
			sck_d  <= sck_s2;
			si_s1  <= i_si;
			si_s2  <= si_s1;
			wp_s1  <= i_wp_n;
			wp_s2  <= wp_s1;
		end
	end

	logic cs_fall, cs_rise, sck_rise, sck_fall;

	// SCK edges seen only while selected
	assign cs_fall  = cs_d & ~cs_s2;
	assign cs_rise  = ~cs_d & cs_s2;
	assign sck_rise = sck_s2 & ~sck_d & ~cs_s2;
	assign sck_fall = ~sck_s2 & sck_d & ~cs_s2;

	// ----------------------------------------------------------------
	// Guard bit store
	// ----------------------------------------------------------------
	sfp_nv_if nv_bus ();

	sfp_guard_store u_store (
		.i_clk      (i_clk),
		.i_nv_rst_n (i_nv_rst_n),
		.nv         (nv_bus.store)
	);

	// ----------------------------------------------------------------
	// Command engine
	// ----------------------------------------------------------------
	sfp_state_e        state_reg, state_next;
	logic [2:0]        bit_cnt_reg, bit_cnt_next;
	logic [1:0]        byte_cnt_reg, byte_cnt_next;
	logic [7:0]        rx_reg, rx_next;
	logic [ADDR_W-1:0] addr_sh_reg, addr_sh_next;
	logic [7:0]        tx_reg, tx_next;
	logic              so_reg, so_next;
	logic              so_on_reg, so_on_next;
	logic              mode3_reg, mode3_next;
	logic              latch_reg, latch_next;
	logic              clr_pend_reg, clr_pend_next;
	logic              pin_en_reg, pin_en_next;
	logic [7:0]        opc_reg, opc_next;
	logic              opc_v_reg, opc_v_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic              addr_v_reg, addr_v_next;
	logic [7:0]        data_reg, data_next;
	logic              data_v_reg, data_v_next;
	logic              permit_reg, permit_next;
	logic [7:0]        status_reg, status_now;
	logic              sel_reg, sel_next;
	logic              end_reg, end_next;
	logic              nv_wr;
	logic [1:0]        nv_data;
	logic [7:0]        rx_full;
	logic              byte_done;
	logic              sr_locked;
	logic              sw_try;

	// Live status byte with fixed bits forced
	always_comb begin
		status_now              = SR_FIXED;
		status_now[SR_PIN_EN]   = pin_en_reg;
		status_now[SR_GUARD_HI] = nv_bus.bits[NV_HI];
		status_now[SR_GUARD_LO] = nv_bus.bits[NV_LO];
		status_now[SR_LATCH]    = latch_reg;
	end

	assign rx_full   = {rx_reg[6:0], si_s2};
	assign byte_done = sck_rise && (bit_cnt_reg == BIT_LAST);
	assign sr_locked = pin_en_reg && !wp_s2;
	assign sw_try    = byte_done && (state_reg == ST_STATUS_IN) && !cs_s2;

	// Next-state and datapath
	always_comb begin
		state_next    = state_reg;
		bit_cnt_next  = bit_cnt_reg;
		byte_cnt_next = byte_cnt_reg;
		rx_next       = rx_reg;
		addr_sh_next  = addr_sh_reg;
		tx_next       = tx_reg;
		so_next       = so_reg;
		so_on_next    = so_on_reg;
		mode3_next    = mode3_reg;
		latch_next    = latch_reg;
		clr_pend_next = clr_pend_reg;
		pin_en_next   = pin_en_reg;
		opc_next      = opc_reg;
		opc_v_next    = 1'b0;
		addr_next     = addr_reg;
		addr_v_next   = 1'b0;
		data_next     = data_reg;
		data_v_next   = 1'b0;
		permit_next   = permit_reg;
		sel_next      = !cs_s2;
		end_next      = cs_rise;
		nv_wr         = 1'b0;
		nv_data       = nv_bus.bits;
		if (cs_s2) begin
			state_next   = ST_IDLE;
			bit_cnt_next = 3'h0;
			so_on_next   = 1'b0;
			permit_next  = 1'b0;
			if (cs_rise && clr_pend_reg) begin
				latch_next = 1'b0;
			end
			clr_pend_next = 1'b0;
		end else if (cs_fall) begin
			state_next    = ST_OPCODE;
			mode3_next    = sck_s2;
			bit_cnt_next  = 3'h0;
			byte_cnt_next = 2'h0;
			so_on_next    = 1'b0;
		end else begin
			// Status byte out, rotating so it repeats
			if (sck_fall && (state_reg == ST_STATUS_OUT)) begin
				so_next    = tx_reg[7];
				tx_next    = {tx_reg[6:0], tx_reg[7]};
				so_on_next = 1'b1;
			end
			if (sck_rise && (state_reg inside {ST_OPCODE, ST_ADDR, ST_DATA, ST_STATUS_IN})) begin
				rx_next      = rx_full;
				bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
				if (state_reg == ST_ADDR) begin
					addr_sh_next = {addr_sh_reg[ADDR_W-2:0], si_s2};
				end
			end
			if (byte_done) begin
				case (state_reg)
					ST_OPCODE: begin
						opc_next   = rx_full;
						opc_v_next = 1'b1;
						state_next = ST_DONE;
						case (rx_full)
							OPC_SET_LATCH: latch_next = 1'b1;
							OPC_CLR_LATCH: clr_pend_next = 1'b1;
							OPC_STATUS_WR: begin
								clr_pend_next = 1'b1;
								state_next    = ST_STATUS_IN;
							end
							OPC_MEM_WRITE: begin
								clr_pend_next = 1'b1;
								state_next    = ST_ADDR;
							end
							OPC_STATUS_RD: begin
								state_next = ST_STATUS_OUT;
								tx_next    = status_now;
							end
							OPC_MEM_READ, OPC_FAST_READ: state_next = ST_ADDR;
							OPC_SLEEP, OPC_IDENT: state_next = ST_DONE;
							default: state_next = ST_IGNORE;
						endcase
					end
					ST_ADDR: begin
						byte_cnt_next = 2'(byte_cnt_reg + 2'h1);
						if (byte_cnt_reg == ADDR_LAST) begin
							addr_next   = {addr_sh_reg[ADDR_W-2:0], si_s2};
							addr_v_next = 1'b1;
							state_next  = ST_DATA;
							permit_next = latch_reg && (opc_reg == OPC_MEM_WRITE) &&
								!sfp_guarded({addr_sh_reg[ADDR_W-2:0], si_s2},
									nv_bus.bits);
						end
					end
					ST_DATA: begin
						data_next   = rx_full;
						data_v_next = 1'b1;
					end
					ST_STATUS_IN: begin
						state_next = ST_DONE;
						if (latch_reg && !sr_locked) begin
							pin_en_next = rx_full[SR_PIN_EN];
							nv_wr       = 1'b1;
							nv_data     = {rx_full[SR_GUARD_HI], rx_full[SR_GUARD_LO]};
						end
					end
					default: state_next = state_reg;
				endcase
			end
		end
	end

	assign nv_bus.wr_en   = nv_wr;
	assign nv_bus.wr_data = nv_data;

	// Register every engine field
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg    <= ST_IDLE;
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 2'h0;
			rx_reg       <= 8'h00;
			addr_sh_reg  <= '0;
			tx_reg       <= 8'h00;
			so_reg       <= 1'b0;
			so_on_reg    <= 1'b0;
			mode3_reg    <= 1'b0;
			latch_reg    <= LATCH_RST;
			clr_pend_reg <= 1'b0;
			pin_en_reg   <= PIN_EN_RST;
			opc_reg      <= 8'h00;
			opc_v_reg    <= 1'b0;
			addr_reg     <= '0;
			addr_v_reg   <= 1'b0;
			data_reg     <= 8'h00;
			data_v_reg   <= 1'b0;
			permit_reg   <= 1'b0;
			status_reg   <= SR_FIXED;
			sel_reg      <= 1'b0;
			end_reg      <= 1'b0;
		end else begin
			state_reg    <= state_next;
			bit_cnt_reg  <= bit_cnt_next;
			byte_cnt_reg <= byte_cnt_next;
			rx_reg       <= rx_next;
			addr_sh_reg  <= addr_sh_next;
			tx_reg       <= tx_next;
			so_reg       <= so_next;
			so_on_reg    <= so_on_next;
			mode3_reg    <= mode3_next;
			latch_reg    <= latch_next;
			clr_pend_reg <= clr_pend_next;
			pin_en_reg   <= pin_en_next;
			opc_reg      <= opc_next;
			opc_v_reg    <= opc_v_next;
			addr_reg     <= addr_next;
			addr_v_reg   <= addr_v_next;
			data_reg     <= data_next;
			data_v_reg   <= data_v_next;
			permit_reg   <= permit_next;
			status_reg   <= status_now;
			sel_reg      <= sel_next;
			end_reg      <= end_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_so           = so_reg;
	assign o_so_oe_n      = !so_on_reg;
	assign o_opcode       = opc_reg;
	assign o_opcode_valid = opc_v_reg;
	assign o_addr         = addr_reg;
	assign o_addr_valid   = addr_v_reg;
	assign o_data_byte    = data_reg;
	assign o_data_valid   = data_v_reg;
	assign o_write_permit = permit_reg;
	assign o_status       = status_reg;
	assign o_mode3        = mode3_reg;
	assign o_selected     = sel_reg;
	assign o_frame_end    = end_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_ignore_hiz: assert property (state_reg == ST_IGNORE |-> o_so_oe_n)
		else $error("output driven after unknown opcode");
	a_desel_hiz: assert property (cs_s2 && $past(cs_s2) |-> o_so_oe_n && state_reg == ST_IDLE)
		else $error("output driven while deselected");
	a_mode_pick: assert property (cs_fall |=> mode3_reg == $past(sck_s2))
		else $error("clock mode not taken from SCK level");
	a_so_on_fall: assert property ($changed(so_reg) |-> $past(sck_fall))
		else $error("serial output changed off a falling edge");
	a_latch_set: assert property (byte_done && state_reg == ST_OPCODE
		&& rx_full == OPC_SET_LATCH |=> latch_reg)
		else $error("set-latch did not set latch");
	a_latch_only: assert property ($rose(latch_reg) |-> $past(byte_done && rx_full == OPC_SET_LATCH
		&& state_reg == ST_OPCODE))
		else $error("latch set by other than set-latch");
	a_latch_clr: assert property (cs_rise && clr_pend_reg |=> !latch_reg ##1 !status_reg[SR_LATCH])
		else $error("latch not cleared at deselect");
	a_fixed_bits: assert property (o_status[6] && o_status[5:4] == 2'h0 && !o_status[0])
		else $error("fixed status bits wrong");
	a_sr_locked: assert property (sw_try && (sr_locked || !latch_reg)
		|=> $stable(pin_en_reg) && $stable(nv_bus.bits))
		else $error("status write not refused");
	a_sr_write: assert property (sw_try && latch_reg && !sr_locked
		|=> ##1 nv_bus.bits == $past({rx_full[SR_GUARD_HI], rx_full[SR_GUARD_LO]}, 2))
		else $error("guard bits not written");
	a_permit: assert property (o_addr_valid && o_write_permit |-> latch_reg
		&& !sfp_guarded(o_addr, nv_bus.bits))
		else $error("write permitted in guarded block");

	c_status_read: cover property (state_reg == ST_STATUS_OUT && !o_so_oe_n);
	c_status_write: cover property (sw_try && latch_reg && !sr_locked);
	c_mode3: cover property (cs_fall && sck_s2);
	c_bad_opcode: cover property (state_reg == ST_IGNORE);

endmodule
`default_nettype wire

// [bench/sfp_spi_master.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// SPI master model: select, clock and data toward the device
// ----------------------------------------------------------------
module sfp_spi_master (
	input  wire logic i_clk,
	input  wire logic i_so,
	input  wire logic i_so_oe_n,
	output logic      o_cs_n,
	output logic      o_sck,
	output logic      o_si
);
	// Idle bus after time zero
	initial begin
		o_cs_n = 1'b1;
		o_sck  = 1'b0;
		o_si   = 1'b0;
	end

	// Wait a number of system clocks
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// One selection; nbits bits sent, rx keeps the last eight seen
	task automatic frame(input logic m3, input logic [7:0] b[$], input int nbits,
		output logic [7:0] rx);
		int i;
		rx = 8'h00;
		o_sck <= m3;
		tick(4);
		o_cs_n <= 1'b0;
		tick(8);
		for (i = 0; i < nbits; i++) begin
			o_sck <= 1'b0;
			o_si  <= b[i / 8][7 - (i % 8)];
			tick(4);
			o_sck <= 1'b1;
			// Undriven output reads as unknown
			rx = {rx[6:0], (i_so_oe_n ? 1'bx : i_so)};
			tick(4);
		end
		o_sck <= m3;
		tick(4);
		o_cs_n <= 1'b1;
		o_si   <= ~o_si; // Released line shows no stale level
		tick(8);
	endtask
endmodule
`default_nettype wire

// [bench/spi_fram_cmd_protect_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module spi_fram_cmd_protect_tb;
	import sfp_pkg::*;
	typedef struct packed {logic [7:0] op; logic m3; logic [7:0] st;} sfp_op_row_s;
	typedef struct packed {logic [1:0] g; logic wl; logic [23:0] a; logic ep;} sfp_gd_row_s;
	logic        clk, rst_n, nv_rst_n, wp_n, cs_n, sck, si, so, so_oe_n;
	logic        addr_valid, write_permit, mode3, av_d, cap_permit;
	logic        opv, fe, selected, data_valid;
	logic [7:0]  opcode, status, rx, data_byte, cap_data;
	int          n_opv, n_fe, n_sel, n_dv;
	logic [17:0] addr, cap_addr;
	int          num_errors, total_checks;
	sfp_op_row_s rows [9] = '{'{OPC_SET_LATCH, 1'b0, 8'h42}, '{OPC_STATUS_RD, 1'b1, 8'h42},
		'{OPC_STATUS_WR, 1'b0, 8'h40}, '{OPC_MEM_READ, 1'b1, 8'h40},
		'{OPC_FAST_READ, 1'b0, 8'h40}, '{OPC_MEM_WRITE, 1'b1, 8'h40},
		'{OPC_SLEEP, 1'b0, 8'h40}, '{OPC_IDENT, 1'b1, 8'h40}, '{OPC_CLR_LATCH, 1'b0, 8'h40}};
	sfp_gd_row_s grows [7] = '{'{2'h0, 1'b1, 24'h03FFFF, 1'b1}, '{2'h1, 1'b1, 24'h02FFFF, 1'b1},
		'{2'h1, 1'b1, 24'h030000, 1'b0}, '{2'h2, 1'b1, 24'hFDFFFF, 1'b1},
		'{2'h2, 1'b1, 24'h020000, 1'b0}, '{2'h3, 1'b1, 24'h000000, 1'b0},
		'{2'h0, 1'b0, 24'h000000, 1'b0}};

	sfp_cmd_protect uut (
		.i_clk          (clk),
		.i_rst_n        (rst_n),
		.i_nv_rst_n     (nv_rst_n),
		.i_cs_n         (cs_n),
		.i_sck          (sck),
		.i_si           (si),
		.i_wp_n         (wp_n),
		.o_so           (so),
		.o_so_oe_n      (so_oe_n),
		.o_opcode       (opcode),
		.o_opcode_valid (opv),
		.o_addr         (addr),
		.o_addr_valid   (addr_valid),
		.o_data_byte    (data_byte),
		.o_data_valid   (data_valid),
		.o_write_permit (write_permit),
		.o_status       (status),
		.o_mode3        (mode3),
		.o_selected     (selected),
		.o_frame_end    (fe)
	);

	sfp_spi_master m (
		.i_clk     (clk),
		.i_so      (so),
		.i_so_oe_n (so_oe_n),
		.o_cs_n    (cs_n),
		.o_sck     (sck),
		.o_si      (si)
	);

	// Clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Capture permit, address and data; count pulses and selected cycles
	always @(posedge clk) begin
		av_d <= addr_valid;
		if (av_d) begin
			cap_permit <= write_permit;
			cap_addr   <= addr;
		end
		if (data_valid) begin
			cap_data <= data_byte;
		end
		if (!rst_n) begin
			n_opv <= 0;
			n_fe  <= 0;
			n_sel <= 0;
			n_dv  <= 0;
		end else begin
			n_opv <= n_opv + int'(opv);
			n_fe  <= n_fe + int'(fe);
			n_sel <= n_sel + int'(selected);
			n_dv  <= n_dv + int'(data_valid);
		end
	end

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Whole-byte frame
	task automatic send(input logic m3, input logic [7:0] b[$]);
		int opv0, fe0, sel0;
		opv0 = n_opv;
		fe0  = n_fe;
		sel0 = n_sel;
		m.frame(m3, b, b.size() * 8, rx);
		check(n_opv - opv0, 1);
		check(n_fe - fe0, 1);
		check(n_sel - sel0, 12 + 64 * b.size());
		check(selected, 1'b0);
	endtask

	// Status read; trailing byte is a stray set-latch that must be ignored
	task automatic rd_st(input logic m3, input logic [7:0] exp);
		send(m3, '{OPC_STATUS_RD, OPC_SET_LATCH});
		check(rx, exp);
	endtask

	// Enable then write status
	task automatic wr_st(input logic [7:0] v);
		send(1'b0, '{OPC_SET_LATCH});
		send(1'b0, '{OPC_STATUS_WR, v});
	endtask

	// Verdict
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		#(25 * 30000);
		num_errors++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		nv_rst_n = 1'b0;
		wp_n = 1'b1;
		num_errors = 0;
		total_checks = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		nv_rst_n <= 1'b1;
		@(posedge clk);
		check(status, 8'h40);
		check(so_oe_n, 1'b1);
		// Opcode table in both modes
		foreach (rows[i]) begin
			send(rows[i].m3, '{rows[i].op, 8'h00, 8'h00, 8'h00});
			check(opcode, rows[i].op);
			check(mode3, rows[i].m3);
			check(status, rows[i].st);
		end
		rd_st(1'b0, 8'h40);
		rd_st(1'b1, 8'h40);
		send(1'b0, '{OPC_STATUS_WR, 8'h8C});
		rd_st(1'b0, 8'h40);
		send(1'b1, '{OPC_SET_LATCH});
		rd_st(1'b1, 8'h42);
		send(1'b0, '{OPC_CLR_LATCH});
		rd_st(1'b0, 8'h40);
		rd_st(1'b0, 8'h40);
		wr_st(8'hBF);
		rd_st(1'b0, 8'hCC);
		wp_n <= 1'b0;
		wr_st(8'h00);
		rd_st(0, 8'hCC);
		wp_n <= 1'b1;
		wr_st(8'h04);
		rd_st(1'b0, 8'h44);
		wp_n <= 1'b0;
		wr_st(8'h08);
		rd_st(1'b0, 8'h48);
		wp_n <= 1'b1;
		// Guard ranges at block edges
		foreach (grows[i]) begin
			wr_st({4'h0, grows[i].g, 2'h0});
			if (grows[i].wl)
				send(1'b0, '{OPC_SET_LATCH});
			send(1'b0, '{OPC_MEM_WRITE, grows[i].a[23:16], grows[i].a[15:8], grows[i].a[7:0],
				8'h1D});
			check(cap_permit, grows[i].ep);
			check(cap_addr, grows[i].a[17:0]);
			check(cap_data, 8'h1D);
			check(n_dv, i + 1);
		end
		// Partial opcode dropped at deselect
		m.frame(1'b0, '{OPC_SET_LATCH}, 7, rx);
		rd_st(1'b0, 8'h40);
		// Unknown opcode leaves output undriven
		send(1'b0, '{8'h55, 8'h00});
		check(rx, 8'hxx);
		// Guards survive a power reset, pin enable does not
		wr_st(8'h84);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd_st(1'b0, 8'h44);
		tally_and_finish();
	end
endmodule
`default_nettype wire
